/* rtl/hsi_defs.svh */
// Summary of operation
// - The block returns its acknowledge output to its deasserted level once a host port access is complete.
// - Every host port access other than the compressed data word keeps acknowledge high for one wait cycle or more.
// - In decode a full compressed data FIFO holds acknowledge high until one location is free again.
// - In encode an empty compressed data FIFO holds acknowledge high until one location holds a word.
// - The FIFO service request output is active high and is high only while the host must service the FIFO.
// - In encode the service request is low while the software reset bit is cleared and rises at the nearly-full threshold.
// - In decode the service request is high while the software reset bit is cleared and falls once the FIFO passes nearly-empty.
// - The statistics-ready output rises once per field after the statistics registers have been updated.
// - The last-word output is high while the next host read of the FIFO returns the last compressed word of the field.
// - The host interrupt is raised by any enabled source of FIFO stop, service request, FIFO error, last word, statistics ready and timing-code error, each readable in the status register.
// - The active level of the host interrupt is chosen by a bit of the mode control register.
// - The chip reset returns every register of the block to its reset value.
// - Chip select low qualifies the host strobes, and chip select high keeps the data bus undriven.
// - A host write takes effect at the rising edge of the write strobe, and a read lasts while the read strobe is low.
// - With a 16-bit host the FIFO pointer only moves at the end of an access in which the upper-word enables were asserted.
`ifndef HSI_DEFS_SVH
`define HSI_DEFS_SVH
`define HSI_FIFO_DEPTH 10'h0200
`define HSI_FIFO_AW 9
`define HSI_CNT_W 10
`define HSI_REG_MODE 3'h0
`define HSI_REG_FCTL 3'h1
`define HSI_REG_ISTAT 3'h2
`define HSI_REG_IEN 3'h3
`define HSI_REG_ICLR 3'h4
`define HSI_REG_LEVEL 3'h5
`define HSI_MODE_RST 3'h0
`define HSI_FCTL_RST 20'h1_01C0
`define HSI_IRQ_N 6
`define HSI_IRQ_STOP 0
`define HSI_IRQ_SRQ 1
`define HSI_IRQ_ERR 2
`define HSI_IRQ_LAST 3
`define HSI_IRQ_STATS 4
`define HSI_IRQ_CODE 5
`endif

/* rtl/hsi_pkg.sv */
package hsi_pkg;
  typedef struct packed {
    logic software_reset_bit; // cleared holds the fifo flushed, set runs
    logic pol_high;  // interrupt output active high when set
    logic encode;    // 1 encode, 0 decode
  } hsi_mode_s;
  typedef struct packed {
    logic [9:0] ne;  // nearly-empty level
    logic [9:0] nf;  // nearly-full level
  } hsi_fctl_s;
  typedef struct packed {
    logic last;      // last word of a field
    logic [31:0] word;
  } hsi_fword_s;
  typedef logic [5:0] hsi_irq_t;
  typedef enum logic [1:0] {HA_IDLE, HA_WAIT, HA_ACK} hsi_acc_e;
endpackage : hsi_pkg

/* rtl/hsi_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hsi_defs.svh"
module hsi_fifo import hsi_pkg::*; (
  input wire logic sys_clk_i,         // clock
  input wire logic rst_i,             // sync reset
  input wire logic flush_i,           // empties the fifo
  input wire logic push_i,            // write one word
  input wire hsi_fword_s wdata_i,     // word written
  input wire logic pop_i,             // drop head word
  output hsi_fword_s head_o,          // head word
  output logic [9:0] cnt_o,           // words held
  output logic full_o,                // no free location
  output logic empty_o                // no word held
);
  hsi_fword_s mem [0:`HSI_FIFO_DEPTH-1];
  logic [`HSI_FIFO_AW-1:0] wptr_q;
  logic [`HSI_FIFO_AW-1:0] rptr_q;
  logic [9:0] cnt_q;
  wire do_push = push_i && !full_o;
  wire do_pop = pop_i && !empty_o;

  assign head_o = mem[rptr_q];
  assign cnt_o = cnt_q;
  assign full_o = (cnt_q == `HSI_FIFO_DEPTH);
  assign empty_o = (cnt_q == 10'h000);

  always_ff @(posedge sys_clk_i) begin
    if (do_push) begin
      mem[wptr_q] <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || flush_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end else begin
      wptr_q <= wptr_q + `HSI_FIFO_AW'(do_push);
      rptr_q <= rptr_q + `HSI_FIFO_AW'(do_pop);
      cnt_q <= cnt_q + 10'(do_push) - 10'(do_pop);
    end
  end
endmodule : hsi_fifo
`default_nettype wire

/* rtl/hsi_irq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hsi_defs.svh"
module hsi_irq import hsi_pkg::*; (
  input wire logic sys_clk_i,         // clock
  input wire logic rst_i,             // sync reset
  input wire hsi_irq_t ev_i,          // one-cycle source events
  input wire hsi_irq_t en_i,          // enable mask
  input wire logic clr_we_i,          // clear register written
  input wire hsi_irq_t clr_i,         // ones clear status bits
  input wire logic pol_high_i,        // output active level
  output hsi_irq_t status_o,          // sticky status
  output logic irq_o                  // interrupt pin level
);
  hsi_irq_t status_q;
  genvar i;
  generate
    for (i = 0; i < `HSI_IRQ_N; i++) begin : g_bit
      // a set in the clear cycle must win, or the event is lost
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          status_q[i] <= 1'b0;
        end else if (ev_i[i]) begin
          status_q[i] <= 1'b1;
        end else if (clr_we_i && clr_i[i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign status_o = status_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b1; // idle level, polarity resets to active low
    end else begin
      irq_o <= (|(status_q & en_i)) ~^ pol_high_i;
    end
  end
endmodule : hsi_irq
`default_nettype wire

/* rtl/hsi_host_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hsi_defs.svh"
module hsi_host_port import hsi_pkg::*; (
  input wire logic sys_clk_i,             // 100 MHz clock
  input wire logic rst_i,                 // sync reset, active high
  // -------------------------------------------------------------
  // register bus
  // -------------------------------------------------------------
  input wire logic [2:0] avs_address,     // word address
  input wire logic avs_read,              // read request
  input wire logic avs_write,             // write request
  input wire logic [31:0] avs_writedata,  // write data
  input wire logic [3:0] avs_byteenable,  // byte lanes
  output logic [31:0] avs_readdata,       // read data
  output logic avs_waitrequest,           // stall
  // -------------------------------------------------------------
  // host strobe port
  // -------------------------------------------------------------
  input wire logic host_cs_n_i,           // chip select
  input wire logic host_rd_n_i,           // read strobe
  input wire logic host_wr_n_i,           // write strobe
  input wire logic host_sel_data_i,       // 1 compressed data word
  input wire logic lower_word_enables_n_i, // low word lanes
  input wire logic upper_word_enables_n_i, // high word lanes
  input wire logic [31:0] host_data_i,    // data from host
  output logic [31:0] host_data_o,        // data to host
  output logic host_data_oe_o,            // data bus driven
  output logic host_ack_n_o,              // access acknowledge
  // -------------------------------------------------------------
  // codec core side
  // -------------------------------------------------------------
  input wire logic enc_valid_i,           // encoded word offered
  input wire logic [31:0] enc_word_i,     // encoded word
  input wire logic enc_last_i,            // last word of field
  output logic enc_ready_o,               // fifo takes word
  input wire logic dec_ready_i,           // core takes word
  output logic dec_valid_o,               // word for decoder
  output logic [31:0] dec_word_o,         // word for decoder
  input wire logic core_stop_i,           // fifo stop event
  input wire logic stats_upd_i,           // statistics updated
  input wire logic field_start_i,         // new field begins
  input wire logic vid_code_err_i,        // bad timing code
  // -------------------------------------------------------------
  // status pins
  // -------------------------------------------------------------
  output logic fifo_service_request_o,    // fifo needs service
  output logic statistics_ready_out_o,    // statistics readable
  output logic last_field_word_flag_o,    // next read is last word
  output logic host_interrupt_out_o       // host interrupt
);
  // -------------------------------------------------------------
  // register file
  // -------------------------------------------------------------
  hsi_mode_s mode_q;
  hsi_fctl_s fctl_q;
  hsi_irq_t ien_q;
  hsi_irq_t istat;
  logic [31:0] rdata_d;
  logic wait_q;

  wire avl_req = avs_read || avs_write;
  wire avl_take = avl_req && !wait_q;
  wire wr_mode = avl_take && avs_write && (avs_address == `HSI_REG_MODE);
  wire wr_fctl = avl_take && avs_write && (avs_address == `HSI_REG_FCTL);
  wire wr_ien = avl_take && avs_write && (avs_address == `HSI_REG_IEN);
  wire wr_iclr = avl_take && avs_write && (avs_address == `HSI_REG_ICLR);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  wire [31:0] mode_w = merge({29'h0, mode_q}, avs_writedata, avs_byteenable);
  wire [31:0] fctl_w = merge({6'h0, fctl_q.ne, 6'h0, fctl_q.nf}, avs_writedata,
                             avs_byteenable);
  wire [31:0] ien_w = merge({26'h0, ien_q}, avs_writedata, avs_byteenable);
  wire [9:0] fcnt;

  always_comb begin
    unique case (avs_address)
      `HSI_REG_MODE: rdata_d = {29'h0, mode_q};
      `HSI_REG_FCTL: rdata_d = {6'h0, fctl_q.ne, 6'h0, fctl_q.nf};
      `HSI_REG_ISTAT: rdata_d = {26'h0, istat};
      `HSI_REG_IEN: rdata_d = {26'h0, ien_q};
      `HSI_REG_LEVEL: rdata_d = {22'h0, fcnt};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // one wait cycle per bus access keeps read data a flop
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wait_q <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      mode_q <= `HSI_MODE_RST;
      fctl_q <= `HSI_FCTL_RST;
      ien_q <= '0;
    end else begin
      wait_q <= !(avl_req && wait_q);
      if (avl_req && wait_q) begin
        avs_readdata <= avs_read ? rdata_d : 32'h0000_0000;
      end
      if (wr_mode) begin
        mode_q <= mode_w[2:0];
      end
      if (wr_fctl) begin
        fctl_q <= {fctl_w[25:16], fctl_w[9:0]};
      end
      if (wr_ien) begin
        ien_q <= ien_w[5:0];
      end
    end
  end
  assign avs_waitrequest = wait_q;

  // -------------------------------------------------------------
  // compressed data fifo
  // -------------------------------------------------------------
  hsi_fword_s head;
  hsi_fword_s push_word;
  logic fifo_full;
  logic fifo_empty;
  logic host_push;
  logic host_pop;
  logic dec_pop;
  logic enc_push;

  hsi_fifo u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .flush_i(!mode_q.software_reset_bit),
    .push_i(enc_push || host_push),
    .wdata_i(push_word),
    .pop_i(host_pop || dec_pop),
    .head_o(head),
    .cnt_o(fcnt),
    .full_o(fifo_full),
    .empty_o(fifo_empty)
  );

  // -------------------------------------------------------------
  // host strobe access
  // -------------------------------------------------------------
  hsi_acc_e state_q;
  hsi_acc_e state_d;
  logic rd_acc_q;
  logic lo_seen_q;
  logic hi_seen_q;
  logic [31:0] wdata_q;
  logic [15:0] hold_lo_q;

  wire acc_active = !host_cs_n_i && (!host_rd_n_i || !host_wr_n_i);
  wire acc_rd = !host_wr_n_i ? 1'b0 : 1'b1;
  wire dir_ok = mode_q.encode ? acc_rd : !acc_rd;
  wire data_ok = !dir_ok || (mode_q.encode ? !fifo_empty : !fifo_full);
  wire done = (state_q == HA_ACK) && !acc_active;
  wire lo_seen = lo_seen_q || !lower_word_enables_n_i;
  wire hi_seen = hi_seen_q || !upper_word_enables_n_i;
  wire data_done = done && host_sel_data_i && hi_seen_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      HA_IDLE: begin
        if (acc_active) begin
          state_d = (host_sel_data_i && data_ok) ? HA_ACK : HA_WAIT;
        end
      end
      HA_WAIT: begin
        if (!acc_active) begin
          state_d = HA_IDLE;
        end else if (!host_sel_data_i || data_ok) begin
          state_d = HA_ACK;
        end
      end
      HA_ACK: begin
        if (!acc_active) begin
          state_d = HA_IDLE;
        end
      end
    endcase
  end

  // pointer moves only once the upper word has been touched
  assign host_pop = data_done && mode_q.encode && rd_acc_q;
  assign host_push = data_done && !mode_q.encode && !rd_acc_q;
  assign enc_push = mode_q.encode && enc_valid_i && enc_ready_o;
  assign dec_pop = !mode_q.encode && mode_q.software_reset_bit && !fifo_empty
                   && (!dec_valid_o || dec_ready_i);
  assign push_word.last = mode_q.encode ? enc_last_i : 1'b0;
  assign push_word.word = mode_q.encode ? enc_word_i
                        : {wdata_q[31:16], lo_seen_q ? wdata_q[15:0] : hold_lo_q};

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= HA_IDLE;
      host_ack_n_o <= 1'b1;
      rd_acc_q <= 1'b0;
      lo_seen_q <= 1'b0;
      hi_seen_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      hold_lo_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      host_ack_n_o <= !(state_d == HA_ACK);
      if (acc_active) begin
        rd_acc_q <= acc_rd;
        lo_seen_q <= lo_seen;
        hi_seen_q <= hi_seen;
        if (!host_wr_n_i) begin
          wdata_q <= host_data_i;
        end
      end else begin
        lo_seen_q <= 1'b0;
        hi_seen_q <= 1'b0;
      end
      if (done && host_sel_data_i && !rd_acc_q && lo_seen_q && !hi_seen_q) begin
        hold_lo_q <= wdata_q[15:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      host_data_o <= 32'h0000_0000;
      host_data_oe_o <= 1'b0;
    end else begin
      host_data_oe_o <= !host_cs_n_i && !host_rd_n_i;
      host_data_o <= host_sel_data_i ? head.word : {26'h0, istat};
    end
  end

  // -------------------------------------------------------------
  // core side and status pins
  // -------------------------------------------------------------
  wire srq_d = mode_q.encode ? (fcnt >= fctl_q.nf) : (fcnt <= fctl_q.ne);
  wire last_d = mode_q.encode && !fifo_empty && head.last;
  wire stats_d = stats_upd_i || (statistics_ready_out_o && !field_start_i);
  wire [9:0] cnt_next = fcnt + 10'(enc_push) - 10'(host_pop);
  hsi_irq_t ev;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      enc_ready_o <= 1'b0;
      dec_valid_o <= 1'b0;
      dec_word_o <= 32'h0000_0000;
      fifo_service_request_o <= 1'b0;
      statistics_ready_out_o <= 1'b0;
      last_field_word_flag_o <= 1'b0;
    end else begin
      enc_ready_o <= mode_q.encode && mode_q.software_reset_bit
                     && (cnt_next < `HSI_FIFO_DEPTH);
      if (!mode_q.software_reset_bit || mode_q.encode) begin
        dec_valid_o <= 1'b0;
      end else if (dec_pop) begin
        dec_valid_o <= 1'b1;
        dec_word_o <= head.word;
      end else if (dec_ready_i) begin
        dec_valid_o <= 1'b0;
      end
      fifo_service_request_o <= srq_d;
      statistics_ready_out_o <= stats_d;
      last_field_word_flag_o <= last_d;
    end
  end

  // level sources report their rising edge, pulses report directly
  assign ev[`HSI_IRQ_STOP] = core_stop_i;
  assign ev[`HSI_IRQ_SRQ] = srq_d && !fifo_service_request_o;
  // direction comes from the latched access, the strobes are already up here
  assign ev[`HSI_IRQ_ERR] = (enc_valid_i && mode_q.encode && !enc_ready_o)
                            || (data_done && (mode_q.encode != rd_acc_q));
  assign ev[`HSI_IRQ_LAST] = last_d && !last_field_word_flag_o;
  assign ev[`HSI_IRQ_STATS] = stats_d && !statistics_ready_out_o;
  assign ev[`HSI_IRQ_CODE] = vid_code_err_i;

  hsi_irq u_irq (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ev_i(ev),
    .en_i(ien_q),
    .clr_we_i(wr_iclr),
    .clr_i(avs_writedata[5:0]),
    .pol_high_i(mode_q.pol_high),
    .status_o(istat),
    .irq_o(host_interrupt_out_o)
  );

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_reg_wait_ack: assert property ((state_q == HA_IDLE && acc_active && !host_sel_data_i)
    |=> host_ack_n_o ##1 (!host_ack_n_o || !acc_active))
    else $error("register access acknowledged without a wait cycle");
  a_full_holds_ack: assert property ((!mode_q.encode && acc_active && !acc_rd
    && host_sel_data_i && fifo_full && state_q != HA_ACK) |=> host_ack_n_o)
    else $error("acknowledge given while fifo full in decode");
  a_empty_holds_ack: assert property ((mode_q.encode && acc_active && acc_rd
    && host_sel_data_i && fifo_empty && state_q != HA_ACK) |=> host_ack_n_o)
    else $error("acknowledge given while fifo empty in encode");
  a_ack_releases: assert property ((!host_ack_n_o && !acc_active) |=> host_ack_n_o)
    else $error("acknowledge outlived the access");
  a_srq_in_reset: assert property (($stable(mode_q) && !mode_q.software_reset_bit) [*3]
    |-> (fifo_service_request_o == !mode_q.encode))
    else $error("service request wrong during software reset");
  a_srq_level: assert property ((mode_q.encode && mode_q.software_reset_bit)
    |=> fifo_service_request_o == ($past(fcnt) >= $past(fctl_q.nf)))
    else $error("encode service request does not track nearly full");
  a_pop_needs_hi: assert property (host_pop |-> hi_seen_q && rd_acc_q)
    else $error("fifo advanced without upper word");
  a_stats_pin: assert property (stats_upd_i |=> statistics_ready_out_o)
    else $error("statistics ready missed");
  a_last_word: assert property ((mode_q.encode && !fifo_empty && head.last)
    |=> last_field_word_flag_o)
    else $error("last word flag missed");
  a_irq_level: assert property (((|(istat & ien_q)) && $stable(mode_q.pol_high))
    |=> host_interrupt_out_o == mode_q.pol_high)
    else $error("interrupt output at wrong level");
  a_oe_cs: assert property (host_cs_n_i |=> !host_data_oe_o)
    else $error("data bus driven without chip select");
  a_avl_wait: assert property ((avl_req && wait_q) |=> !wait_q)
    else $error("register bus wait longer than one cycle");

  c_dec_stall: cover property (host_ack_n_o && fifo_full && acc_active ##[1:50] !host_ack_n_o);
  c_enc_read: cover property (host_pop);
  c_irq: cover property ($changed(host_interrupt_out_o));
  c_stats: cover property (stats_upd_i ##1 field_start_i);
endmodule : hsi_host_port
`default_nettype wire

/* testbench/hsi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hsi_host_model (
  input wire logic sys_clk_i,     // clock
  input wire logic ack_n_i,       // acknowledge from block
  input wire logic [31:0] data_i, // bus from block
  output logic cs_n_o,            // chip select
  output logic rd_n_o,            // read strobe
  output logic wr_n_o,            // write strobe
  output logic sel_o,             // compressed data word access
  output logic [31:0] data_o      // bus to block
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    sel_o = 1'b0;
    data_o = 32'h0000_0000;
  end
  // strobes stay down until ack is seen low at an edge; no timeout of its own
  task automatic access(input logic wr, input logic sel, input logic [31:0] d,
                        output logic [31:0] q, output int waits);
    waits = 0;
    cs_n_o <= 1'b0;
    sel_o <= sel;
    data_o <= d;
    wr_n_o <= !wr;
    rd_n_o <= wr;
    @(posedge sys_clk_i);
    while (ack_n_i !== 1'b0) begin
      waits++;
      @(posedge sys_clk_i);
    end
    q = data_i;
    cs_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    data_o <= ~d; // released bus must not look like the last word
    @(posedge sys_clk_i);
  endtask : access
endmodule : hsi_host_model
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst, avs_rd, avs_wr, enc_valid, enc_last, dec_ready, lo_n, hi_n;
  logic [3:0] ev;
  logic [2:0] avs_addr;
  logic [31:0] avs_wdata, enc_word, q;
  wire logic [31:0] avs_rdata, hd_o, hd_i, dec_word;
  wire logic avs_wait, oe, ack_n, cs_n, rd_n, wr_n, sel, enc_ready, dec_valid;
  wire logic srq, stats, last, irq;
  int n_errors = 0;
  int checked = 0;
  int n;
  hsi_host_port u_dut (.sys_clk_i(clk), .rst_i(rst), .avs_address(avs_addr),
    .avs_read(avs_rd), .avs_write(avs_wr), .avs_writedata(avs_wdata),
    .avs_byteenable(4'hf), .avs_readdata(avs_rdata), .avs_waitrequest(avs_wait),
    .host_cs_n_i(cs_n), .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .host_sel_data_i(sel),
    .lower_word_enables_n_i(lo_n), .upper_word_enables_n_i(hi_n), .host_data_i(hd_i),
    .host_data_o(hd_o), .host_data_oe_o(oe), .host_ack_n_o(ack_n),
    .enc_valid_i(enc_valid), .enc_word_i(enc_word), .enc_last_i(enc_last),
    .enc_ready_o(enc_ready), .dec_ready_i(dec_ready), .dec_valid_o(dec_valid),
    .dec_word_o(dec_word), .core_stop_i(ev[0]), .stats_upd_i(ev[1]),
    .field_start_i(ev[2]), .vid_code_err_i(ev[3]), .fifo_service_request_o(srq),
    .statistics_ready_out_o(stats), .last_field_word_flag_o(last),
    .host_interrupt_out_o(irq));
  // an undriven bus reads as the inverse, so a late enable shows up
  hsi_host_model host (.sys_clk_i(clk), .ack_n_i(ack_n), .data_i(oe ? hd_o : ~hd_o),
    .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .sel_o(sel), .data_o(hd_i));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic avs(input logic w, input logic [2:0] a, input logic [31:0] d);
    avs_wr <= w;
    avs_rd <= !w;
    avs_addr <= a;
    avs_wdata <= d;
    @(posedge clk);
    while (avs_wait !== 1'b0) @(posedge clk);
    q = avs_rdata;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
    @(posedge clk);
  endtask : avs
  task automatic push(input logic [31:0] w, input logic l);
    enc_valid <= 1'b1;
    enc_word <= w;
    enc_last <= l;
    @(posedge clk);
    while (enc_ready !== 1'b1) @(posedge clk);
    enc_valid <= 1'b0;
    @(posedge clk);
  endtask : push
  task automatic fire(input int k);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev <= 4'h0;
    repeat (3) @(posedge clk);
  endtask : fire
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    @(posedge clk);
    chk(ack_n, 1'b1);
    chk(oe, 1'b0);
    chk(srq, 1'b1);
    chk(irq, 1'b1);
    avs(1'b0, 3'h0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    avs(1'b0, 3'h1, 32'h0000_0000);
    chk(q, 32'h0040_01C0);
    avs(1'b0, 3'h6, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_decode;
    int i;
    avs(1'b1, 3'h1, 32'h0002_01C0);
    avs(1'b1, 3'h0, 32'h0000_0004);
    repeat (3) @(posedge clk);
    chk(srq, 1'b1);
    host.access(1'b0, 1'b0, 32'h0000_0000, q, n);
    chk(n >= 2, 1'b1);
    hi_n <= 1'b1;
    host.access(1'b1, 1'b1, 32'h0000_5678, q, n);
    avs(1'b0, 3'h5, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    lo_n <= 1'b1;
    hi_n <= 1'b0;
    host.access(1'b1, 1'b1, 32'h1234_0000, q, n);
    lo_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk(dec_word, 32'h1234_5678);
    i = 0;
    q = 32'h0000_0000;
    while (q !== 32'h0000_0200 && i < 600) begin
      host.access(1'b1, 1'b1, 32'hD000_0000 + i, q, n);
      avs(1'b0, 3'h5, 32'h0000_0000);
      i++;
    end
    chk(q, 32'h0000_0200);
    chk(srq, 1'b0);
    fork
      host.access(1'b1, 1'b1, 32'hABCD_0001, q, n);
      begin
        repeat (30) @(posedge clk);
        chk(ack_n, 1'b1);
        dec_ready <= 1'b1;
        @(posedge clk);
        dec_ready <= 1'b0;
      end
    join
    chk(n >= 30, 1'b1);
    chk(dec_valid, 1'b1);
    chk(dec_word, 32'hD000_0000);
    $display("test decode done");
  endtask : t_decode
  task automatic t_encode;
    avs(1'b1, 3'h0, 32'h0000_0001);
    avs(1'b1, 3'h0, 32'h0000_0005);
    avs(1'b1, 3'h1, 32'h0002_0002);
    repeat (3) @(posedge clk);
    chk(srq, 1'b0);
    push(32'h1111_0001, 1'b0);
    push(32'h2222_0002, 1'b1);
    repeat (3) @(posedge clk);
    chk(srq, 1'b1);
    chk(last, 1'b0);
    host.access(1'b0, 1'b1, 32'h0000_0000, q, n);
    chk(q, 32'h1111_0001);
    repeat (3) @(posedge clk);
    chk(last, 1'b1);
    host.access(1'b0, 1'b1, 32'h0000_0000, q, n);
    chk(q, 32'h2222_0002);
    fork
      host.access(1'b0, 1'b1, 32'h0000_0000, q, n);
      begin
        repeat (20) @(posedge clk);
        push(32'h3333_0003, 1'b0);
      end
    join
    chk(n >= 20, 1'b1);
    chk(q, 32'h3333_0003);
    $display("test encode done");
  endtask : t_encode
  task automatic t_irq;
    int src[3] = '{0, 1, 3};
    int bitpos[3] = '{0, 4, 5};
    avs(1'b0, 3'h2, 32'h0000_0000);
    chk(q, 32'h0000_000A);
    avs(1'b1, 3'h4, 32'h0000_003F);
    avs(1'b1, 3'h3, 32'h0000_0031);
    foreach (src[i]) begin
      fire(src[i]);
      avs(1'b0, 3'h2, 32'h0000_0000);
      chk(q[bitpos[i]], 1'b1);
      chk(irq, 1'b0);
      avs(1'b1, 3'h4, 32'h0000_003F);
      repeat (3) @(posedge clk);
      chk(irq, 1'b1);
    end
    chk(stats, 1'b1);
    fire(2);
    chk(stats, 1'b0);
    avs(1'b1, 3'h0, 32'h0000_0007);
    fire(0);
    chk(irq, 1'b1);
    avs(1'b1, 3'h4, 32'h0000_003F);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    $display("test interrupt done");
  endtask : t_irq
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    complete_run;
  end
  initial begin
    rst = 1'b1;
    avs_rd = 1'b0;
    avs_wr = 1'b0;
    avs_addr = 3'h0;
    avs_wdata = 32'h0000_0000;
    enc_valid = 1'b0;
    enc_last = 1'b0;
    enc_word = 32'h0000_0000;
    dec_ready = 1'b0;
    lo_n = 1'b0;
    hi_n = 1'b0;
    ev = 4'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_decode;
    t_encode;
    t_irq;
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
